/* logic/sleep_key_status.sv */
/*
  Sleep key status byte: request and wake flags, write-one-to-clear,
  read back over the i/o cycle, and a combined general event status output.
  Assumes i/o strobes are single-cycle and synchronous to the clock.
*/
`timescale 1ns/1ps
module sleep_key_status (
  input  wire logic                     clk_in,
  input  wire logic                     reset_in,
  input  wire sleep_wake_pkg::io_req_t  io_req_in,
  input  wire logic                     press_in,
  input  wire logic                     asleep_in,
  output logic [7:0]                    rdata_out,
  output logic                          gpe_status_out,
  output logic                          request_out,
  output logic                          wake_out
);

  logic       hit;
  logic [1:0] clr;
  logic [1:0] set;
  logic [7:0] flags_q;
  logic [7:0] rdata_q;

  // ==========================================================================
  // decode and flag update
  // ==========================================================================
  assign hit    = (io_req_in.addr == sleep_wake_pkg::SLEEP_KEY_PORT_ADDR);
  assign clr[0] = hit & io_req_in.wr & io_req_in.wdata[sleep_wake_pkg::KEY_REQUEST_BIT];
  assign clr[1] = hit & io_req_in.wr & io_req_in.wdata[sleep_wake_pkg::KEY_WAKE_BIT];
  assign set[0] = press_in & ~asleep_in;  // press while working asks for sleep
  assign set[1] = press_in & asleep_in;   // press while asleep marks wake source

  // set wins over a same-cycle clear so no press is lost
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      flags_q <= sleep_wake_pkg::SLEEP_KEY_RESET;
    end else begin
      flags_q[0] <= set[0] | (flags_q[0] & ~clr[0]);
      flags_q[1] <= set[1] | (flags_q[1] & ~clr[1]);
      flags_q[7:2] <= 6'h00;                          // reserved bits stay zero
    end
  end

  // read data registered; idle bus shows zero
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_q <= sleep_wake_pkg::RDATA_RESET;
    end else begin
      rdata_q <= (hit & io_req_in.rd) ? flags_q : sleep_wake_pkg::RDATA_RESET;
    end
  end

  assign rdata_out      = rdata_q;
  assign request_out    = flags_q[0];
  assign wake_out       = flags_q[1];
  assign gpe_status_out = flags_q[0] | flags_q[1];

  // ==========================================================================
  // checks
  // ==========================================================================
  a_w1c_clears_flag: assert property (@(posedge clk_in) disable iff (reset_in)
    (clr[0] & ~set[0]) |=> ~flags_q[0]) else $error("request flag not cleared by write one");
  a_zero_write_keeps: assert property (@(posedge clk_in) disable iff (reset_in)
    (flags_q[1] & ~clr[1]) |=> flags_q[1]) else $error("wake flag lost without write one");
  a_request_bit_place: assert property (@(posedge clk_in) disable iff (reset_in)
    (hit & io_req_in.rd) |=> (rdata_out[0] == $past(flags_q[0]))) else $error("request bit misplaced");
  a_wake_bit_place: assert property (@(posedge clk_in) disable iff (reset_in)
    (hit & io_req_in.rd) |=> (rdata_out[1] == $past(flags_q[1]))) else $error("wake bit misplaced");
  a_event_feed: assert property (@(posedge clk_in) disable iff (reset_in)
    set[0] |=> gpe_status_out) else $error("general event status not fed");

endmodule // sleep_key_status

/* logic/sleep_wake_pkg.sv */
/*
  Shared constants and types for the sleep and wake sequencer:
  platform state codes, the sleep key I/O byte layout and sequencing times.
  Assumes a 50 MHz power-management clock.
*/
package sleep_wake_pkg;

  // ==========================================================================
  // clock and sequencing times
  // ==========================================================================
  localparam int CLK_PERIOD_NS   = 20;
  localparam int ENTRY_TIME_NS   = 100;  // least time spent powering down
  localparam int WAKE_TIME_NS    = 160;  // least time spent powering up
  localparam int CNT_W           = 4;
  localparam int ENTRY_CYCLES_I  = (ENTRY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CYCLES_I   = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] ENTRY_CYCLES = ENTRY_CYCLES_I[CNT_W-1:0];
  localparam logic [CNT_W-1:0] WAKE_CYCLES  = WAKE_CYCLES_I[CNT_W-1:0];
  localparam logic [CNT_W-1:0] CNT_RESET    = 4'h0;

  // ==========================================================================
  // sleep kind codes, as software loads them into the kind field
  // ==========================================================================
  localparam logic [2:0] KIND_WORKING = 3'h0;
  localparam logic [2:0] KIND_S1      = 3'h1;
  localparam logic [2:0] KIND_S4      = 3'h4;
  localparam logic [2:0] KIND_S5      = 3'h5;

  // ==========================================================================
  // sleep key status byte
  // ==========================================================================
  localparam logic [15:0] SLEEP_KEY_PORT_ADDR = 16'h0201;
  localparam int          KEY_REQUEST_BIT     = 0;
  localparam int          KEY_WAKE_BIT        = 1;
  localparam logic [7:0]  SLEEP_KEY_RESET     = 8'h00;
  localparam logic [7:0]  RDATA_RESET         = 8'h00;

  // i/o cycle carried as one bundle
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
  } io_req_t;

  // one-hot sequencer states
  typedef enum logic [4:0] {
    ST_WORKING  = 5'b00001,
    ST_ENTERING = 5'b00010,
    ST_SLEEPING = 5'b00100,
    ST_WAKING   = 5'b01000,
    ST_OFF      = 5'b10000
  } seq_state_t;

endpackage

/* logic/sleep_wake_sequencer.sv */
/*
  Sleep and wake sequencer: takes a sleep kind and a trigger from software,
  walks the platform into S1-S4 or soft-off, returns it on a wake event,
  keeps the wake flag, and forces soft-off on a power key override.
  Holds the sleep key status byte at i/o address 0x201.
  Assumes all inputs are synchronous to CLK_SYS_IN and the override input
  is already qualified by the external power key hold timer.
*/
`timescale 1ns/1ps
module sleep_wake_sequencer #(
  parameter bit SUPPORT_LIGHT_SLEEP = 1'b1
) (
  input  wire logic                     CLK_SYS_IN,
  input  wire logic                     RESET_IN,
  input  wire logic [2:0]               SLEEP_KIND_SELECT_IN,
  input  wire logic                     SLEEP_TRIGGER_IN,
  input  wire logic                     POWER_KEY_OVERRIDE_IN,
  input  wire logic                     WAKE_EVENT_IN,
  input  wire logic                     WAKE_FLAG_CLEAR_IN,
  input  wire logic                     SLEEP_KEY_PRESS_IN,
  input  wire sleep_wake_pkg::io_req_t  IO_REQ_IN,
  output logic [7:0]                    IO_RDATA_OUT,
  output logic                          WAKE_FLAG_OUT,
  output logic [2:0]                    PLATFORM_STATE_OUT,
  output logic                          SEQ_BUSY_OUT,
  output logic                          RESUME_TO_OS_OUT,
  output logic                          RESET_VECTOR_OUT,
  output logic                          POWER_KEY_STATUS_CLEAR_OUT,
  output logic                          GENERAL_EVENT_STATUS_0_OUT
);

  sleep_wake_pkg::seq_state_t state_q;
  logic [2:0]                          kind_q;
  logic [2:0]                          plat_q;
  logic [sleep_wake_pkg::CNT_W-1:0]    cnt_q;
  logic                                trig_prev_q;
  logic                                wake_flag_q;
  logic                                resume_q;
  logic                                vector_q;
  logic                                pk_clr_q;
  logic                                trig_rise;
  logic                                kind_ok;
  logic                                accept;
  logic                                wake_any;
  logic                                asleep;
  logic                                cnt_done;
  logic                                wake_from_sleep;

  // ==========================================================================
  // request qualification
  // ==========================================================================
  assign trig_rise = SLEEP_TRIGGER_IN & ~trig_prev_q;
  assign kind_ok   = (SLEEP_KIND_SELECT_IN >= sleep_wake_pkg::KIND_S1) &&
                     (SLEEP_KIND_SELECT_IN <= sleep_wake_pkg::KIND_S5);
  // only the working state takes a trigger; a busy sequence drops it
  assign accept    = trig_rise & kind_ok & (state_q == sleep_wake_pkg::ST_WORKING)
                     & ~POWER_KEY_OVERRIDE_IN;
  assign asleep    = (state_q == sleep_wake_pkg::ST_SLEEPING) | (state_q == sleep_wake_pkg::ST_OFF);
  assign wake_any  = WAKE_EVENT_IN | SLEEP_KEY_PRESS_IN;
  assign cnt_done  = (cnt_q == sleep_wake_pkg::CNT_RESET);
  assign wake_from_sleep = (state_q == sleep_wake_pkg::ST_SLEEPING) & wake_any & ~POWER_KEY_OVERRIDE_IN;

  // trigger edge detector, so a held bit does not re-arm after wake
  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= SLEEP_TRIGGER_IN;
    end
  end

  // ==========================================================================
  // sequencer
  // ==========================================================================
  // override has priority over every other path
  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state_q <= sleep_wake_pkg::ST_WORKING;
      kind_q  <= sleep_wake_pkg::KIND_WORKING;
      cnt_q   <= sleep_wake_pkg::CNT_RESET;
    end else if (POWER_KEY_OVERRIDE_IN && state_q != sleep_wake_pkg::ST_OFF) begin
      state_q <= sleep_wake_pkg::ST_OFF;
      kind_q  <= sleep_wake_pkg::KIND_S5;
      cnt_q   <= sleep_wake_pkg::CNT_RESET;
    end else begin
      unique case (state_q)
        sleep_wake_pkg::ST_WORKING: begin
          if (accept) begin
            state_q <= sleep_wake_pkg::ST_ENTERING;
            kind_q  <= SLEEP_KIND_SELECT_IN;
            cnt_q   <= sleep_wake_pkg::ENTRY_CYCLES - 4'h1;
          end
        end
        sleep_wake_pkg::ST_ENTERING: begin
          if (!cnt_done) begin
            cnt_q <= cnt_q - 4'h1;
          end else if (kind_q == sleep_wake_pkg::KIND_S5) begin
            state_q <= sleep_wake_pkg::ST_OFF;
          end else begin
            state_q <= sleep_wake_pkg::ST_SLEEPING;
          end
        end
        sleep_wake_pkg::ST_SLEEPING: begin
          if (wake_any) begin
            state_q <= sleep_wake_pkg::ST_WAKING;
            cnt_q   <= sleep_wake_pkg::WAKE_CYCLES - 4'h1;
          end
        end
        sleep_wake_pkg::ST_OFF: begin
          // override still held must not bounce the platform back on
          if (wake_any && !POWER_KEY_OVERRIDE_IN) begin
            state_q <= sleep_wake_pkg::ST_WAKING;
            cnt_q   <= sleep_wake_pkg::WAKE_CYCLES - 4'h1;
          end
        end
        sleep_wake_pkg::ST_WAKING: begin
          if (!cnt_done) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            state_q <= sleep_wake_pkg::ST_WORKING;
          end
        end
        default: begin
          state_q <= sleep_wake_pkg::ST_WORKING;  // recover from a broken code
        end
      endcase
    end
  end

  // platform state code shown to the outside
  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      plat_q <= sleep_wake_pkg::KIND_WORKING;
    end else if (POWER_KEY_OVERRIDE_IN && state_q != sleep_wake_pkg::ST_OFF) begin
      plat_q <= sleep_wake_pkg::KIND_S5;
    end else if (state_q == sleep_wake_pkg::ST_ENTERING && cnt_done) begin
      plat_q <= kind_q;
    end else if (state_q == sleep_wake_pkg::ST_WAKING && cnt_done) begin
      plat_q <= sleep_wake_pkg::KIND_WORKING;
    end
  end

  // ==========================================================================
  // wake flag and exit pulses
  // ==========================================================================
  // set wins over a same-cycle clear
  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      wake_flag_q <= 1'b0;
    end else if (!SUPPORT_LIGHT_SLEEP) begin
      wake_flag_q <= 1'b0;
    end else begin
      wake_flag_q <= wake_from_sleep | (wake_flag_q & ~WAKE_FLAG_CLEAR_IN);
    end
  end

  // lightest state resumes in place, deeper ones restart from the vector
  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      resume_q <= 1'b0;
      vector_q <= 1'b0;
    end else begin
      resume_q <= (state_q == sleep_wake_pkg::ST_WAKING) & cnt_done & ~POWER_KEY_OVERRIDE_IN
                  & (kind_q == sleep_wake_pkg::KIND_S1);
      vector_q <= (state_q == sleep_wake_pkg::ST_WAKING) & cnt_done & ~POWER_KEY_OVERRIDE_IN
                  & (kind_q != sleep_wake_pkg::KIND_S1);
    end
  end

  // one pulse per override event outside soft-off clears the power key status; none while already off
  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      pk_clr_q <= 1'b0;
    end else begin
      pk_clr_q <= POWER_KEY_OVERRIDE_IN & (state_q != sleep_wake_pkg::ST_OFF);
    end
  end

  // ==========================================================================
  // sleep key status byte
  // ==========================================================================
  sleep_key_status u_key_status (
    .clk_in         (CLK_SYS_IN),
    .reset_in       (RESET_IN),
    .io_req_in      (IO_REQ_IN),
    .press_in       (SLEEP_KEY_PRESS_IN),
    .asleep_in      (asleep),
    .rdata_out      (IO_RDATA_OUT),
    .gpe_status_out (GENERAL_EVENT_STATUS_0_OUT),
    .request_out    (),
    .wake_out       ()
  );

  assign WAKE_FLAG_OUT              = wake_flag_q;
  assign PLATFORM_STATE_OUT         = plat_q;
  assign SEQ_BUSY_OUT               = (state_q == sleep_wake_pkg::ST_ENTERING) |
                                      (state_q == sleep_wake_pkg::ST_WAKING);
  assign RESUME_TO_OS_OUT           = resume_q;
  assign RESET_VECTOR_OUT           = vector_q;
  assign POWER_KEY_STATUS_CLEAR_OUT = pk_clr_q;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RESET_IN);

  sequence s_wake_finish;
    (state_q == sleep_wake_pkg::ST_WAKING && cnt_done && !POWER_KEY_OVERRIDE_IN);
  endsequence

  sequence s_light_kind;
    (kind_q == sleep_wake_pkg::KIND_S1);
  endsequence

  a_trigger_starts_entry: assert property (accept |=> state_q == sleep_wake_pkg::ST_ENTERING
    ##0 kind_q == $past(SLEEP_KIND_SELECT_IN)) else $error("trigger did not start entry");
  a_entry_reaches_kind: assert property ($rose(state_q == sleep_wake_pkg::ST_ENTERING)
    ##0 (!POWER_KEY_OVERRIDE_IN)[*6] |=> plat_q == kind_q) else $error("entry did not reach kind");
  a_override_forces_off: assert property ((POWER_KEY_OVERRIDE_IN && state_q != sleep_wake_pkg::ST_OFF)
    |=> state_q == sleep_wake_pkg::ST_OFF && plat_q == sleep_wake_pkg::KIND_S5) else $error("override ignored");
  a_override_clears_key: assert property ((POWER_KEY_OVERRIDE_IN && state_q != sleep_wake_pkg::ST_OFF)
    |=> POWER_KEY_STATUS_CLEAR_OUT) else $error("power key status not cleared");
  a_wake_leaves_sleep: assert property (wake_from_sleep |=> state_q == sleep_wake_pkg::ST_WAKING
    ##[8:9] state_q == sleep_wake_pkg::ST_WORKING) else $error("wake did not return to working");
  a_wake_sets_flag: assert property ($rose(wake_flag_q) |->
    $past(state_q == sleep_wake_pkg::ST_SLEEPING)) else $error("wake flag set outside sleeping");
  a_flag_zero_unsupported: assert property (!SUPPORT_LIGHT_SLEEP |-> !WAKE_FLAG_OUT)
    else $error("wake flag set without lightest state");
  a_resume_path: assert property (s_wake_finish ##0 s_light_kind |=> RESUME_TO_OS_OUT && !RESET_VECTOR_OUT)
    else $error("lightest wake did not resume os");
  a_vector_path: assert property (s_wake_finish ##0 (kind_q != sleep_wake_pkg::KIND_S1)
    |=> RESET_VECTOR_OUT && !RESUME_TO_OS_OUT) else $error("deep wake did not restart vector");
  a_busy_drops_trigger: assert property ($rose(state_q == sleep_wake_pkg::ST_ENTERING) |->
    $past(state_q == sleep_wake_pkg::ST_WORKING)) else $error("trigger taken while busy");
  // a rising trigger while busy must leave the latched kind alone
  a_busy_keeps_kind: assert property ((trig_rise && state_q != sleep_wake_pkg::ST_WORKING
    && !POWER_KEY_OVERRIDE_IN) |=> $stable(kind_q)) else $error("kind changed by trigger while busy");
  a_flag_holds: assert property ((wake_flag_q && !WAKE_FLAG_CLEAR_IN) |=> wake_flag_q)
    else $error("wake flag lost without clear");

endmodule // sleep_wake_sequencer

/* tb/tb_top.sv */
/*
  Self-checking bench for the sleep and wake sequencer: sleep entry for
  every kind, wake, override, refusals and the sleep key status byte.
  Assumes the design package is compiled first and one 50 MHz clock.
*/
`timescale 1ns/1ps
module tb_top;
  typedef struct { int due; int w; logic [7:0] v; } note_t;
  logic                    clk_sys_in = 1'b0;
  logic                    reset_in   = 1'b1;
  logic [2:0]              kind       = 3'h0;
  logic                    trig       = 1'b0;
  logic                    ovr        = 1'b0;
  logic                    wake       = 1'b0;
  logic                    wclr       = 1'b0;
  logic                    press      = 1'b0;
  sleep_wake_pkg::io_req_t io_req     = '0;
  logic [7:0]              rdata;
  logic                    wflag, busy, resume, rvec, pkclr, gpe;
  logic                    wflag_nl;
  logic [2:0]              pstate;
  note_t                   q[$];
  note_t                   n;
  logic [7:0]              got;
  int                      ncnt = 0;
  int                      cyc = 0;
  int                      errors = 0;
  int                      samples_checked = 0;
  int                      seed = 32'h0000_a09b;
  int                      r;
  string                   nm[9] = '{"rdata", "wake_flag", "state", "busy", "resume", "reset_vec", "key_clr",
                                     "gpe", "nl_wake_flag"};

  sleep_wake_sequencer #(.SUPPORT_LIGHT_SLEEP(1'b1)) u_dut (
    .CLK_SYS_IN(clk_sys_in), .RESET_IN(reset_in), .SLEEP_KIND_SELECT_IN(kind), .SLEEP_TRIGGER_IN(trig),
    .POWER_KEY_OVERRIDE_IN(ovr), .WAKE_EVENT_IN(wake), .WAKE_FLAG_CLEAR_IN(wclr), .SLEEP_KEY_PRESS_IN(press),
    .IO_REQ_IN(io_req), .IO_RDATA_OUT(rdata), .WAKE_FLAG_OUT(wflag), .PLATFORM_STATE_OUT(pstate),
    .SEQ_BUSY_OUT(busy), .RESUME_TO_OS_OUT(resume), .RESET_VECTOR_OUT(rvec),
    .POWER_KEY_STATUS_CLEAR_OUT(pkclr), .GENERAL_EVENT_STATUS_0_OUT(gpe));

  // second copy without the lightest state: its wake flag must never rise
  sleep_wake_sequencer #(.SUPPORT_LIGHT_SLEEP(1'b0)) u_dut_no_light (
    .CLK_SYS_IN(clk_sys_in), .RESET_IN(reset_in), .SLEEP_KIND_SELECT_IN(kind), .SLEEP_TRIGGER_IN(trig),
    .POWER_KEY_OVERRIDE_IN(ovr), .WAKE_EVENT_IN(wake), .WAKE_FLAG_CLEAR_IN(wclr), .SLEEP_KEY_PRESS_IN(press),
    .IO_REQ_IN(io_req), .IO_RDATA_OUT(), .WAKE_FLAG_OUT(wflag_nl), .PLATFORM_STATE_OUT(),
    .SEQ_BUSY_OUT(), .RESUME_TO_OS_OUT(), .RESET_VECTOR_OUT(),
    .POWER_KEY_STATUS_CLEAR_OUT(), .GENERAL_EVENT_STATUS_0_OUT());

  // ==========================================================================
  // clock, timeout and scoreboard
  // ==========================================================================
  always #10 clk_sys_in = ~clk_sys_in;

  // ceiling well above the roughly 350 cycles the tests need
  always @(posedge clk_sys_in) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      errors = errors + 1;
      end_of_test();
    end
  end

  // outputs are settled at the falling edge, so notes are judged there
  always @(negedge clk_sys_in) begin
    ncnt = ncnt + 1;
    while (q.size() > 0 && q[0].due <= ncnt) begin
      n = q.pop_front();
      case (n.w)
        0: got = rdata;
        1: got = {7'h00, wflag};
        2: got = {5'h00, pstate};
        3: got = {7'h00, busy};
        4: got = {7'h00, resume};
        5: got = {7'h00, rvec};
        6: got = {7'h00, pkclr};
        7: got = {7'h00, gpe};
        default: got = {7'h00, wflag_nl};
      endcase
      samples_checked = samples_checked + 1;
      if (got !== n.v) begin
        errors = errors + 1;
        $display("ERROR %s expected %h seen %h", nm[n.w], n.v, got);
      end
    end
  end

  // ==========================================================================
  // tasks
  // ==========================================================================
  // note a value due at cycle c of a request launched at this edge
  task automatic note(input int w, input logic [7:0] v, input int c);
    q.push_back('{ncnt + 1 + c, w, v});
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_in);
  endtask

  // one i/o cycle; a read notes the data due one cycle later
  task automatic io(input logic [15:0] a, input bit wr, input logic [7:0] d, input logic [7:0] e);
    @(posedge clk_sys_in);
    io_req <= '{a, wr, ~wr, d};
    if (!wr) note(0, e, 1);
    @(posedge clk_sys_in);
    io_req <= '0;
  endtask

  // sleep into kind k, retrigger while entering, then wake by event or key
  task automatic sleep_wake(input logic [2:0] k, input bit by_key);
    @(posedge clk_sys_in);
    kind <= k;
    trig <= 1'b1;
    note(3, 1, 1); note(2, k, 6); note(3, 0, 6);
    @(posedge clk_sys_in);
    trig <= 1'b0;
    tick(2);
    kind <= 3'h2;
    trig <= 1'b1;
    note(2, k, 9);
    @(posedge clk_sys_in);
    trig <= 1'b0;
    r = $random(seed);
    tick(10 + (r & 7));
    if (by_key) press <= 1'b1;
    else wake <= 1'b1;
    if (k != 3'h5) note(1, 1, 1);
    note(8, 0, 1);
    if (by_key) note(7, 1, 1);
    note(3, 1, 1); note(2, 0, 9); note(4, k == 3'h1, 9); note(5, k != 3'h1, 9);
    note(4, 0, 10); note(5, 0, 10);
    @(posedge clk_sys_in);
    press <= 1'b0;
    wake <= 1'b0;
    tick(14);
    if (k != 3'h5) note(1, 1, 0);
    wclr <= 1'b1;
    note(1, 0, 1);
    @(posedge clk_sys_in);
    wclr <= 1'b0;
    if (by_key) io(16'h0201, 1'b0, 8'h00, 8'h02);
    io(16'h0201, 1'b1, 8'hff, 8'h00);
    note(7, 0, 0);
    $display("test sleep kind %0d done", k);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    tick(4);
    reset_in <= 1'b0;
    note(2, 0, 0); note(7, 0, 0); note(1, 0, 0); note(3, 0, 0);
    io(16'h0201, 1'b0, 8'h00, 8'h00);
    for (int k = 1; k <= 5; k++) sleep_wake(k[2:0], 1'b0);
    sleep_wake(3'h1, 1'b1);
    sleep_wake(3'h4, 1'b1);
    // codes outside 1..5 are refused
    @(posedge clk_sys_in);
    kind <= 3'h6;
    trig <= 1'b1;
    note(3, 0, 1); note(2, 0, 7);
    @(posedge clk_sys_in);
    trig <= 1'b0;
    tick(8);
    $display("test refusal done");
    // override aborts an entry, blocks wake while held
    @(posedge clk_sys_in);
    kind <= 3'h3;
    trig <= 1'b1;
    @(posedge clk_sys_in);
    trig <= 1'b0;
    tick(1);
    ovr <= 1'b1;
    note(2, 5, 1); note(6, 1, 1); note(3, 0, 1); note(6, 0, 2);
    tick(4);
    wake <= 1'b1;
    note(2, 5, 10);
    @(posedge clk_sys_in);
    wake <= 1'b0;
    tick(12);
    ovr <= 1'b0;
    @(posedge clk_sys_in);
    wake <= 1'b1;
    note(1, 0, 1); note(2, 0, 9); note(5, 1, 9);
    @(posedge clk_sys_in);
    wake <= 1'b0;
    tick(12);
    $display("test override done");
    // sleep key byte: set, masked clears, unmapped place
    press <= 1'b1;
    note(7, 1, 1);
    @(posedge clk_sys_in);
    press <= 1'b0;
    io(16'h0201, 1'b0, 8'h00, 8'h01);
    io(16'h0200, 1'b0, 8'h00, 8'h00);
    r = $random(seed);
    io(16'h0201, 1'b1, {r[7:2], 2'b10}, 8'h00);
    io(16'h0201, 1'b0, 8'h00, 8'h01);
    io(16'h0201, 1'b1, {r[15:10], 2'b01}, 8'h00);
    note(7, 0, 0);
    io(16'h0201, 1'b0, 8'h00, 8'h00);
    tick(4);
    $display("test sleep key done");
    end_of_test();
  end
endmodule // tb_top
